// ==== bench/ipl_link_assertions.sv ====
// ipl_link_assertions: timing and framing checks on the serial link
// assumes: instantiated beside the link interface, sees only its signals
`timescale 1ns/1ps
module ipl_link_assertions
  import ipl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link signals
  input wire logic link_clk,
  input wire logic cmd,
  input wire logic frame_start,
  input wire logic stat,
  input wire logic delayed_reset_out_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [3:0] low_cnt_reg;
  logic lclk_reg;
  logic [3:0] bit_reg;
  logic [15:0] sh_reg;
  logic [15:0] word_reg;
  logic wdone_reg;
  logic [5:0] gap_reg;
  logic seen_reg;
  logic lrise;
  logic [3:0] idx;
  assign lrise = link_clk & ~lclk_reg;
  assign idx = frame_start ? 4'h0 : bit_reg;
  // ****
  // rebuild words and marker spacing
  // ****
  always_ff @(posedge clk_sys)
  begin
    lclk_reg <= link_clk;
    wdone_reg <= lrise && !sys_rst && idx == 4'hf;
    if (sys_rst)
    begin
      low_cnt_reg <= 4'h1;
      bit_reg <= 4'h0;
      gap_reg <= 6'h0;
      seen_reg <= 1'b0;
    end
    else
    begin
      if (!delayed_reset_out_n && low_cnt_reg != 4'hf)
        low_cnt_reg <= low_cnt_reg + 4'h1;
      if (lrise)
      begin
        bit_reg <= idx + 4'h1;
        sh_reg <= {cmd, sh_reg[15:1]};
        if (idx == 4'hf)
          word_reg <= {cmd, sh_reg[15:1]};
        if (frame_start)
          gap_reg <= gap_reg + 6'h1;
        if (idx == 4'(MF_SYNC_MARKER_BIT) && cmd)
        begin
          gap_reg <= 6'h0;
          seen_reg <= 1'b1;
        end
      end
    end
  end
  a_reset_hold_time: assert property ($rose(delayed_reset_out_n) |-> low_cnt_reg >= 4'(RST_CYC))
    else $error("port reset released too early");
  a_link_half_period: assert property ($changed(link_clk) |=> $stable(link_clk)[*3])
    else $error("link clock half period too short");
  a_cmd_on_fall: assert property ($changed(cmd) |-> $fell(link_clk))
    else $error("command bit changed away from link clock fall");
  a_frame_start_len: assert property ($rose(frame_start) |-> frame_start[*8] ##1 !frame_start)
    else $error("frame start not one link bit long");
  a_frame_spacing: assert property ($fell(frame_start) |-> ##120 $rose(frame_start))
    else $error("frame not sixteen link bits long");
  a_stat_stands: assert property ($changed(stat) |=> $stable(stat)[*7])
    else $error("status bit shorter than a link bit");
  a_marker_period: assert property (lrise && idx == 4'(MF_SYNC_MARKER_BIT) && cmd && seen_reg |-> gap_reg == 6'(MF_LINK_FRAMES))
    else $error("marker spacing not forty frames");
  a_marker_overdue: assert property (seen_reg |-> gap_reg <= 6'(MF_LINK_FRAMES))
    else $error("marker missing after forty frames");
  a_p2p_txen_forced: assert property (wdone_reg && cmd_op(word_reg) == OP_CHANNEL_LOOP_CONFIG
    && cmd_mode(word_reg) == MODE_P2P && (word_reg[LOOP_BIT] || word_reg[EXTERNAL_LOOP_ENABLE_BIT])
    |-> word_reg[TXEN_BIT])
    else $error("point-to-point loop sent without transmit enable");
endmodule : ipl_link_assertions

// ==== bench/isdn_port_loop_and_violation_ctrl_tb.sv ====
// isdn_port_loop_and_violation_ctrl_tb: controller and port joined over the link
// assumes: software port driven by tasks; line events driven by the bench
`timescale 1ns/1ps
module isdn_port_loop_and_violation_ctrl_tb;
  import ipl_pkg::*;
  localparam int NCH_TB = 6;
  localparam int CYC_LIMIT = 40000;
  localparam logic [3:0] DEV_VER = 4'h6; // arbitrary value
  localparam logic [2:0] CH [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  localparam logic [1:0] MD [5] = '{MODE_P2P, MODE_NETWORK_SIDE, MODE_NETWORK_SIDE, MODE_TERMINAL_SIDE, MODE_P2P};
  // high byte: loop 01, transparent 02, ext 04, txen 08, opt0 20, opt1 40
  localparam logic [7:0] HI [5] = '{8'h01, 8'h0b, 8'h04, 8'h0b, 8'h01};
  // violation cases: {pulse, framing position, expect report, channel}
  localparam logic [3:0] VT [4] = '{4'b1100, 4'b1111, 4'b0000, 4'b1010};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic [NCH_TB-1:0] viol = '0;
  logic [NCH_TB-1:0] fm_pos = '0;
  logic [NCH_TB-1:0] tx_en, lp_close, lp_fwd, ext_lp, rx_os, rx_d;
  logic clk_src, ready;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  ipl_link_if link ();
  ipl_l1_ctrl #(.LINK_HALF_P(4)) i_ipl_l1_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
    .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  ipl_port_dev #(.NCH(NCH_TB), .VERSION(DEV_VER)) i_ipl_port_dev (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_en(1'b1), .link(link), .line_code_viol(viol), .line_fm_pos(fm_pos), .line_tx_en(tx_en),
    .loop_close(lp_close), .loop_fwd_en(lp_fwd), .ext_loop_en(ext_lp), .rx_oversample(rx_os),
    .rx_dch(rx_d), .term_clk_src(clk_src), .port_ready(ready));
  ipl_link_assertions i_ipl_link_assertions (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link_clk(link.link_clk), .cmd(link.cmd), .frame_start(link.frame_start), .stat(link.stat),
    .delayed_reset_out_n(link.delayed_reset_out_n));
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ****
  // access and check tasks
  // ****
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read
  function automatic logic [31:0] mk(input logic [2:0] op, input logic [2:0] ch, input logic [1:0] md,
    input logic [7:0] hi);
    return {16'h0, hi, md, ch, op};
  endfunction : mk
  // one frame to wait for a free slot, one to carry the word
  task automatic send(input logic [31:0] w);
    reg_write(REG_CMD, w);
    repeat (300) @(posedge clk_sys);
    #1;
  endtask : send
  task automatic wait_irq(input int limit, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < limit && !hit; i++)
    begin
      @(posedge clk_sys);
      #1;
      hit = (irq === 1'b1);
    end
  endtask : wait_irq
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == CYC_LIMIT)
    begin
      mismatches++;
      give_verdict();
    end
  end
  // ****
  // tests
  // ****
  initial
  begin
    logic [31:0] d;
    logic hit;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    reg_read(REG_STAT, d);
    check(32'(d[17]), 32'h0, "port reset held");
    check(32'({tx_en, lp_close, lp_fwd, ext_lp, ready}), 32'h0, "idle outputs");
    reg_read(REG_MASK, d);
    check(d, 32'h0, "mask reset value");
    reg_read(8'h20, d);
    check(d, 32'h0, "unmapped read");
    repeat (20) @(posedge clk_sys);
    reg_read(REG_STAT, d);
    check(32'(d[17]), 32'h1, "port reset released");
    $display("test reset done");
    send(mk(OP_CHANNEL_LOOP_CONFIG, 3'h0, MODE_P2P, 8'h01));
    reg_read(REG_IRQ, d);
    check(d & 32'h4, 32'h4, "order refusal");
    check(32'({lp_close, tx_en, ready}), 32'h0, "unconfigured idle");
    check(32'(irq), 32'h0, "masked interrupt");
    reg_write(REG_MASK, 32'h4);
    repeat (2) @(posedge clk_sys);
    #1;
    check(32'(irq), 32'h1, "unmasked interrupt");
    reg_write(REG_IRQ, 32'h4);
    repeat (2) @(posedge clk_sys);
    #1;
    check(32'(irq), 32'h0, "cleared interrupt");
    reg_write(REG_MASK, 32'h0);
    $display("test order done");
    send(mk(OP_VERSION_READ, 3'h0, 2'h0, 8'h00));
    // the version rides in the status word of the frame after the command
    repeat (130) @(posedge clk_sys);
    reg_read(REG_VER, d);
    check(d & 32'hf, 32'(DEV_VER), "version value");
    reg_read(REG_IRQ, d);
    check(d & 32'h2, 32'h2, "version event");
    send(mk(OP_PORT_CONFIG, 3'h0, 2'h0, 8'h20));
    check(32'({clk_src, ready}), 32'h3, "port setup");
    $display("test version done");
    for (int i = 0; i < 5; i++)
      send(mk(OP_CHANNEL_LOOP_CONFIG, CH[i], MD[i], HI[i]));
    check(32'(tx_en), 32'h03, "transmit enables");
    check(32'(lp_close), 32'h0b, "loops closed");
    check(32'(lp_fwd), 32'h0a, "forward paths");
    check(32'(ext_lp), 32'h04, "external loops");
    send(mk(OP_RX_CONFIG, 3'h0, 2'h0, 8'h60));
    check(32'({rx_os, rx_d}), 32'h041, "receiver options");
    $display("test loops done");
    reg_write(REG_IRQ, 32'hf);
    reg_write(REG_MASK, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      viol[VT[i][0]] <= VT[i][3];
      fm_pos[VT[i][0]] <= VT[i][2];
      @(posedge clk_sys);
      viol <= '0;
      fm_pos <= '0;
      wait_irq(6000, hit);
      check(32'(hit), 32'(VT[i][1]), "violation report");
      reg_write(REG_IRQ, 32'h1);
    end
    $display("test violations done");
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    #1;
    check({tx_en, lp_close, lp_fwd, ext_lp, rx_os, clk_src, ready}, 32'h0, "outputs in reset");
    check(reg_rdata, 32'h0, "read data in reset");
    check(32'({irq, link.delayed_reset_out_n, link.link_clk, link.cmd}), 32'h0, "controller in reset");
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    reg_read(REG_MASK, d);
    check(d, 32'h0, "mask after reset");
    reg_read(REG_STAT, d);
    check(32'(d[17]), 32'h0, "port reset held again");
    repeat (20) @(posedge clk_sys);
    reg_read(REG_STAT, d);
    check(32'(d[17]), 32'h1, "port reset released again");
    $display("test second reset done");
    give_verdict();
  end
endmodule : isdn_port_loop_and_violation_ctrl_tb

// ==== rtl/ipl_l1_ctrl.sv ====
// ipl_l1_ctrl: layer-1 controller end - drives the port over the serial link
// assumes: software on a simple strobe port; port end samples the link
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module ipl_l1_ctrl #(
  parameter int LINK_HALF_P = ipl_pkg::LINK_HALF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // link to port
  ipl_link_if.ctl link,
  // register port
  input wire logic [ipl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // interrupt
  output logic irq
);
  import ipl_pkg::*;

  if (LINK_HALF_P < 4 || LINK_HALF_P > 8 || CMD_W != 2 ** IDX_W)
  begin : g_chk
    $error("ipl_l1_ctrl: LINK_HALF_P must be 4 to 8");
  end

  typedef struct packed {
    logic [2:0] div;
    logic lclk;
    logic cmd;
    logic fs;
    logic rst_n;
    logic [3:0] rst_cnt;
    logic [IDX_W-1:0] bit_i;
    logic [5:0] frame;
    logic pend;
    logic seen;
    logic [CMD_W-1:0] pend_word;
    logic [CMD_W-1:0] tx_word;
    logic [CMD_W-1:0] rx_sh;
    logic [CMD_W-1:0] last_stat;
    logic [3:0] ver;
    logic [1:0] phase;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
  } ipl_ctl_st_t;

  ipl_ctl_st_t st_reg;
  ipl_ctl_st_t st_next;
  logic stat_q;

  // ********************
  // status input synchroniser
  // ********************
  ipl_sync #(.W(1)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d_in(link.stat),
    .q(stat_q),
    .rise(),
    .fall()
  );

  // ********************
  // next state
  // ********************
  always_comb
  begin
    logic [CMD_W-1:0] w;
    logic [CMD_W-1:0] s;
    logic [IDX_W-1:0] nb;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    w = reg_wdata[CMD_W-1:0];
    s = '0;
    nb = '0;
    ev = '0;
    clr = '0;
    st_next = st_reg;
    st_next.rdata = '0;

    // port reset, low for at least the minimum after our own reset
    if (st_reg.rst_cnt != 4'(RST_CYC))
      st_next.rst_cnt = st_reg.rst_cnt + 1'b1;
    st_next.rst_n = (st_next.rst_cnt == 4'(RST_CYC));

    // link clock divider and framing
    if (st_reg.div == 3'(LINK_HALF_P - 1))
    begin
      st_next.div = '0;
      st_next.lclk = ~st_reg.lclk;
      if (st_reg.lclk)
      begin
        // falling edge: put out the next command bit
        nb = (st_reg.bit_i == IDX_W'(CMD_W - 1)) ? '0 : st_reg.bit_i + 1'b1;
        st_next.bit_i = nb;
        if (nb == '0)
        begin
          st_next.tx_word = st_reg.pend ? st_reg.pend_word : {{(CMD_W-3){1'b0}}, OP_NOP};
          st_next.tx_word[MF_SYNC_MARKER_BIT] = (st_reg.frame == '0);
          st_next.frame = (st_reg.frame == 6'(MF_LINK_FRAMES - 1)) ? '0 : st_reg.frame + 1'b1;
          ev[IRQ_SENT] = st_reg.pend;
          st_next.pend = 1'b0;
        end
        st_next.cmd = st_next.tx_word[nb];
        st_next.fs = (nb == '0);
      end
      else
      begin
        // rising edge: the port's bit for the previous slot is settled
        st_next.rx_sh[st_reg.bit_i - 1'b1] = stat_q;
        if (st_reg.bit_i == '0)
        begin
          st_next.seen = 1'b1;
          if (st_reg.seen)
          begin
            s = st_next.rx_sh;
            st_next.last_stat = s;
            ev[IRQ_CV] = s[CODE_VIOLATION_FLAG_BIT];
            if (s[VER_VALID_BIT])
            begin
              st_next.ver = s[VER_LSB +: 4];
              ev[IRQ_VER] = 1'b1;
            end
          end
        end
      end
    end
    else
    begin
      st_next.div = st_reg.div + 1'b1;
    end

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        REG_CMD:
        begin
          if (st_reg.pend || !st_reg.rst_n)
            ev[IRQ_ERR] = 1'b1;
          else if ((cmd_op(w) == OP_CHANNEL_LOOP_CONFIG && st_reg.phase == 2'h0)
            || (cmd_op(w) == OP_RX_CONFIG && st_reg.phase != 2'h2))
            ev[IRQ_ERR] = 1'b1;
          else
          begin
            // loops travel only as channel bits; there is no loop opcode
            w[MF_SYNC_MARKER_BIT] = 1'b0;
            if (cmd_op(w) == OP_CHANNEL_LOOP_CONFIG && cmd_mode(w) == MODE_P2P
              && (w[LOOP_BIT] || w[EXTERNAL_LOOP_ENABLE_BIT]))
              w[TXEN_BIT] = 1'b1;
            st_next.pend = 1'b1;
            st_next.pend_word = w;
            if (cmd_op(w) == OP_PORT_CONFIG && st_reg.phase == 2'h0)
              st_next.phase = 2'h1;
            if (cmd_op(w) == OP_CHANNEL_LOOP_CONFIG)
              st_next.phase = 2'h2;
          end
        end
        REG_IRQ:
          clr = reg_wdata[IRQ_W-1:0];
        REG_MASK:
          st_next.irq_mask = reg_wdata[IRQ_W-1:0];
        default:
          clr = '0;
      endcase
    end

    // register reads, data in the next cycle
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CMD:
          st_next.rdata = 32'(st_reg.pend_word);
        REG_STAT:
          st_next.rdata = {12'h000, st_reg.phase, st_reg.rst_n, st_reg.pend, st_reg.last_stat};
        REG_IRQ:
          st_next.rdata = 32'(st_reg.irq_st);
        REG_MASK:
          st_next.rdata = 32'(st_reg.irq_mask);
        REG_VER:
          st_next.rdata = 32'(st_reg.ver);
        default:
          st_next.rdata = '0;
      endcase
    end

    // a new event wins over a clear in the same cycle
    st_next.irq_st = (st_reg.irq_st & ~clr) | ev;
    st_next.irq = |(st_next.irq_st & st_next.irq_mask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
      st_reg.irq_mask <= IRQ_MASK_RST;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  // ********************
  // outputs
  // ********************
  assign link.link_clk = st_reg.lclk;
  assign link.cmd = st_reg.cmd;
  assign link.frame_start = st_reg.fs;
  assign link.delayed_reset_out_n = st_reg.rst_n;
  assign reg_rdata = st_reg.rdata;
  assign irq = st_reg.irq;
endmodule : ipl_l1_ctrl

// ==== rtl/ipl_link_if.sv ====
// ipl_link_if: serial command/status link between controller and port
// assumes: the controller drives clock, frame start and port reset
`timescale 1ns/1ps
interface ipl_link_if;
  logic link_clk;
  logic cmd;
  logic frame_start;
  logic stat;
  logic delayed_reset_out_n;
  modport dev (
    input link_clk,
    input cmd,
    input frame_start,
    input delayed_reset_out_n,
    output stat
  );
  modport ctl (
    output link_clk,
    output cmd,
    output frame_start,
    output delayed_reset_out_n,
    input stat
  );
endinterface : ipl_link_if

// ==== rtl/ipl_pkg.sv ====
// ipl_pkg: constants shared by both ends of the port control link
// assumes: one command word and one status word per link frame, lsb first
package ipl_pkg;
  // ********************
  // link framing
  // ********************
  localparam int CMD_W = 16;
  localparam int IDX_W = 4;
  localparam int MF_LINK_FRAMES = 40;
  // ********************
  // timing
  // ********************
  localparam int SYS_CLK_NS = 100;
  localparam int RST_MIN_NS = 1000;
  localparam int RST_CYC = (RST_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int LINK_HALF = 4;
  // ********************
  // command word fields
  // ********************
  localparam int OP_LSB = 0;
  localparam int CH_LSB = 3;
  localparam int MODE_LSB = 6;
  localparam int LOOP_BIT = 8;
  localparam int TRANS_BIT = 9;
  localparam int EXTERNAL_LOOP_ENABLE_BIT = 10;
  localparam int TXEN_BIT = 11;
  localparam int MF_SYNC_MARKER_BIT = 12;
  localparam int OPT0_BIT = 13;
  localparam int OPT1_BIT = 14;
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_PORT_CONFIG = 3'h1;
  localparam logic [2:0] OP_CHANNEL_LOOP_CONFIG = 3'h2;
  localparam logic [2:0] OP_RX_CONFIG = 3'h3;
  localparam logic [2:0] OP_VERSION_READ = 3'h4;
  localparam logic [1:0] MODE_P2P = 2'h0;
  localparam logic [1:0] MODE_NETWORK_SIDE = 2'h1;
  localparam logic [1:0] MODE_TERMINAL_SIDE = 2'h2;
  // ********************
  // status word fields
  // ********************
  localparam int CODE_VIOLATION_FLAG_BIT = 0;
  localparam int VER_VALID_BIT = 1;
  localparam int VER_LSB = 2;
  localparam int MAP_LSB = 8;
  // ********************
  // controller registers
  // ********************
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0c;
  localparam logic [7:0] REG_VER = 8'h10;
  localparam int IRQ_W = 4;
  localparam int IRQ_CV = 0;
  localparam int IRQ_VER = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_SENT = 3;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  function automatic logic [2:0] cmd_op(input logic [CMD_W-1:0] w);
    return w[OP_LSB +: 3];
  endfunction : cmd_op

  function automatic logic [2:0] cmd_ch(input logic [CMD_W-1:0] w);
    return w[CH_LSB +: 3];
  endfunction : cmd_ch

  function automatic logic [1:0] cmd_mode(input logic [CMD_W-1:0] w);
    return w[MODE_LSB +: 2];
  endfunction : cmd_mode
endpackage : ipl_pkg

// ==== rtl/ipl_port_dev.sv ====
// ipl_port_dev: line port end - loop control and code violation reporting
// assumes: link pins are asynchronous; line event inputs are on clk_sys
`timescale 1ns/1ps
module ipl_port_dev #(
  parameter int NCH = 8,
  parameter logic [3:0] VERSION = 4'h1 // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // link to controller
  ipl_link_if.dev link,
  // line interface events
  input wire logic [NCH-1:0] line_code_viol,
  input wire logic [NCH-1:0] line_fm_pos,
  // line interface controls
  output logic [NCH-1:0] line_tx_en,
  output logic [NCH-1:0] loop_close,
  output logic [NCH-1:0] loop_fwd_en,
  output logic [NCH-1:0] ext_loop_en,
  output logic [NCH-1:0] rx_oversample,
  output logic [NCH-1:0] rx_dch,
  output logic term_clk_src,
  output logic port_ready
);
  import ipl_pkg::*;

  if (NCH < 1 || NCH > 8)
  begin : g_chk
    $error("ipl_port_dev: NCH must be 1 to 8");
  end

  typedef struct packed {
    logic stat;
    logic [IDX_W-1:0] idx;
    logic [CMD_W-1:0] sh;
    logic [CMD_W-1:0] stat_word;
    logic [5:0] mf_cnt;
    logic port_cfg;
    logic clk_src;
    logic ver_req;
    logic cv_flag;
    logic [NCH-1:0] chan_cfg, loop, trans, ext, txen, os, dch, pend, rep;
    logic [NCH-1:0] tx_out, loop_out, fwd_out, ext_out;
    logic [NCH-1:0][1:0] mode;
  } ipl_dev_st_t;

  ipl_dev_st_t st_reg;
  ipl_dev_st_t st_next;
  logic [3:0] ls_q;
  logic [3:0] ls_rise;

  // ********************
  // link input synchroniser
  // ********************
  ipl_sync #(.W(4)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d_in({link.delayed_reset_out_n, link.frame_start, link.cmd, link.link_clk}),
    .q(ls_q),
    .rise(ls_rise),
    .fall()
  );

  // ********************
  // next state
  // ********************
  always_comb
  begin
    logic [IDX_W-1:0] b;
    logic [CMD_W-1:0] w;
    logic [CMD_W-1:0] sw;
    logic [2:0] ch;
    logic mf_end;
    b = '0;
    w = '0;
    sw = '0;
    ch = '0;
    mf_end = 1'b0;
    st_next = st_reg;
    if (ls_rise[0])
    begin
      b = ls_q[2] ? '0 : st_reg.idx + 1'b1;
      st_next.idx = b;
      st_next.sh[b] = ls_q[1];
      if (b == '0)
      begin
        sw[MAP_LSB +: 8] = 8'(st_reg.rep);
        sw[VER_LSB +: 4] = VERSION;
        sw[VER_VALID_BIT] = st_reg.ver_req;
        sw[CODE_VIOLATION_FLAG_BIT] = st_reg.cv_flag;
        st_next.stat_word = sw;
        st_next.ver_req = 1'b0;
        st_next.cv_flag = 1'b0;
      end
      st_next.stat = st_next.stat_word[b];
      if (b == IDX_W'(CMD_W - 1))
      begin
        w = {ls_q[1], st_reg.sh[CMD_W-2:0]};
        ch = cmd_ch(w);
        // a marker realigns the window, else it wraps by itself
        mf_end = w[MF_SYNC_MARKER_BIT] || st_reg.mf_cnt == 6'(MF_LINK_FRAMES - 1);
        st_next.mf_cnt = mf_end ? '0 : st_reg.mf_cnt + 1'b1;
        if (mf_end)
        begin
          st_next.rep = st_reg.pend;
          st_next.cv_flag = |st_reg.pend;
          st_next.pend = '0;
        end
        case (cmd_op(w))
          OP_PORT_CONFIG:
          begin
            st_next.port_cfg = 1'b1;
            st_next.clk_src = w[OPT0_BIT];
          end
          OP_CHANNEL_LOOP_CONFIG:
          begin
            if (st_reg.port_cfg && int'(ch) < NCH)
            begin
              st_next.chan_cfg[ch] = 1'b1;
              st_next.mode[ch] = cmd_mode(w);
              st_next.loop[ch] = w[LOOP_BIT];
              st_next.trans[ch] = w[TRANS_BIT];
              st_next.ext[ch] = w[EXTERNAL_LOOP_ENABLE_BIT];
              st_next.txen[ch] = w[TXEN_BIT];
            end
          end
          OP_RX_CONFIG:
          begin
            if (int'(ch) < NCH && st_reg.chan_cfg[ch])
            begin
              st_next.os[ch] = w[OPT0_BIT];
              st_next.dch[ch] = w[OPT1_BIT];
            end
          end
          OP_VERSION_READ:
            st_next.ver_req = 1'b1;
          default:
            st_next.ver_req = st_next.ver_req;
        endcase
      end
    end
    // violations arriving at the window edge go into the next window
    for (int i = 0; i < NCH; i++)
    begin
      if (st_reg.chan_cfg[i] && line_code_viol[i] && (st_reg.mode[i] != MODE_P2P || !line_fm_pos[i]))
        st_next.pend[i] = 1'b1;
      st_next.tx_out[i] = st_next.chan_cfg[i] && (!(st_next.loop[i] || st_next.ext[i])
        || (st_next.mode[i] != MODE_TERMINAL_SIDE && st_next.txen[i]));
      st_next.loop_out[i] = st_next.chan_cfg[i] && st_next.loop[i];
      st_next.fwd_out[i] = st_next.chan_cfg[i] && st_next.loop[i] && st_next.trans[i];
      st_next.ext_out[i] = st_next.chan_cfg[i] && st_next.ext[i];
    end
    if (!ls_q[3])
      st_next = '0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      st_reg <= '0;
    else if (clk_en)
      st_reg <= st_next;
  end

  assign link.stat = st_reg.stat;
  assign line_tx_en = st_reg.tx_out;
  assign loop_close = st_reg.loop_out;
  assign loop_fwd_en = st_reg.fwd_out;
  assign ext_loop_en = st_reg.ext_out;
  assign rx_oversample = st_reg.os;
  assign rx_dch = st_reg.dch;
  assign term_clk_src = st_reg.clk_src;
  assign port_ready = st_reg.port_cfg;
endmodule : ipl_port_dev

// ==== rtl/ipl_sync.sv ====
// ipl_sync: two-flop synchroniser with edge pulses
// assumes: d_in is asynchronous to clk_sys
`timescale 1ns/1ps
module ipl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // asynchronous inputs
  input wire logic [W-1:0] d_in,
  // synchronised level and edges
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  if (W < 1)
  begin : g_chk
    $error("ipl_sync: W must be positive");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } ipl_sync_st_t;

  ipl_sync_st_t st_reg;
  ipl_sync_st_t st_next;

  always_comb
  begin
    st_next.s1 = d_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      st_reg <= '0;
    else if (clk_en)
      st_reg <= st_next;
  end

  assign q = st_reg.s2;
  assign rise = st_reg.s2 & ~st_reg.s3;
  assign fall = ~st_reg.s2 & st_reg.s3;
endmodule : ipl_sync
